// ### core/blit_pkg.sv
/*
 Constants shared by the block-transfer control/status bank and its FIFO tracker.
 Assumes a single 40 MHz clock and an AXI4-Lite host with 16-bit byte addresses.
*/
package blit_pkg;
   // Bus
   localparam int unsigned AXI_AW = 16;
   localparam int unsigned AXI_DW = 32;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register byte offsets
   localparam logic [15:0] CTRL_OFS     = 16'h8000;
   localparam logic [15:0] STAT_OFS     = 16'h8004;
   localparam logic [15:0] IRQ_STAT_OFS = 16'h8028;
   localparam logic [15:0] IRQ_MASK_OFS = 16'h802c;

   // Control fields
   localparam int unsigned CTRL_START_BIT   = 0;
   localparam int unsigned CTRL_SRC_LIN_BIT = 16;
   localparam int unsigned CTRL_DST_LIN_BIT = 17;
   localparam int unsigned CTRL_BPP_BIT     = 18;
   localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

   // Status fields
   localparam int unsigned STAT_BUSY_BIT  = 0;
   localparam int unsigned STAT_FULL_BIT  = 4;
   localparam int unsigned STAT_HALF_BIT  = 5;
   localparam int unsigned STAT_NE_BIT    = 6;
   localparam int unsigned STAT_FREE_LSB  = 16;
   localparam int unsigned STAT_USED_LSB  = 24;
   localparam logic [31:0] STAT_RESET     = 32'h0000_0000;

   // Interrupt fields
   localparam int unsigned IRQ_W        = 2;
   localparam int unsigned IRQ_DONE_BIT = 0;
   localparam int unsigned IRQ_FULL_BIT = 1;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

   // FIFO occupancy
   localparam int unsigned CNT_W = 5;
   localparam logic [CNT_W-1:0] FIFO_DEPTH  = 5'h10;
   localparam logic [CNT_W-1:0] HALF_MARK   = 5'h07;
   localparam logic [CNT_W-1:0] FULL_MARK   = 5'h0f;
   localparam logic [CNT_W-1:0] RESUME_MARK = 5'h0e;
   localparam logic [CNT_W-1:0] CNT_RESET   = 5'h00;

   // Engine geometry
   localparam int unsigned ADDR_W = 20;
   localparam int unsigned DIM_W  = 10;
   localparam logic [ADDR_W-1:0] STEP_8BPP  = 20'h00001;
   localparam logic [ADDR_W-1:0] STEP_16BPP = 20'h00002;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
   localparam logic [DIM_W-1:0]  DIM_RESET  = 10'h000;

   typedef enum logic {
      st_idle,
      st_run
   } engine_state_e;
endpackage : blit_pkg

// ### core/fifo_level_if.sv
/*
 Occupancy signals between the engine/register bank and the FIFO level tracker.
 Assumes both ends sit on the same clock.
*/
interface fifo_level_if;
   logic                       push;
   logic                       pop;
   logic                       push_ok;
   logic                       pop_ok;
   logic [blit_pkg::CNT_W-1:0] count;
   logic [blit_pkg::CNT_W-1:0] free;
   logic                       not_empty;
   logic                       half_full;
   logic                       full;

   modport tracker (input push, pop,
                    output push_ok, pop_ok, count, free, not_empty, half_full, full);
   modport user    (output push, pop,
                    input push_ok, pop_ok, count, free, not_empty, half_full, full);
endinterface : fifo_level_if

// ### core/blit_fifo_level.sv
/*
 Occupancy counter and status flags of the 16-entry block-transfer FIFO.
 Assumes push and pop come from logic on the same clock.
*/
module blit_fifo_level (
   // Clock and reset
   input  wire logic  clk,
   input  wire logic  arst_n,
   // Level signals
   fifo_level_if.tracker lvl
);
   logic [blit_pkg::CNT_W-1:0] count;

   // Overflow and underflow requests are dropped, not counted
   assign lvl.push_ok = lvl.push && (count != blit_pkg::FIFO_DEPTH);
   assign lvl.pop_ok  = lvl.pop && (count != blit_pkg::CNT_RESET);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count <= blit_pkg::CNT_RESET;
      end else if (lvl.push_ok && !lvl.pop_ok) begin
         count <= count + 5'h01;
      end else if (lvl.pop_ok && !lvl.push_ok) begin
         count <= count - 5'h01;
      end
   end

   assign lvl.count     = count;
   assign lvl.free      = blit_pkg::FIFO_DEPTH - count;
   assign lvl.not_empty = (count != blit_pkg::CNT_RESET);
   assign lvl.half_full = (count >= blit_pkg::HALF_MARK);
   assign lvl.full      = (count >= blit_pkg::FULL_MARK);
endmodule : blit_fifo_level

// ### core/blit_regs.sv
/*
 Control and status register bank of the 2D block-transfer engine, with the
 row-stepping address walker, FIFO level tracking and a maskable interrupt.
 Assumes an AXI4-Lite master on clk; geometry, FIFO pop and the read/write
 direction come from the surrounding engine datapath on the same clock.
*/
module blit_regs (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   // AXI4-Lite write address and data
   input  wire logic [blit_pkg::AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [blit_pkg::AXI_DW-1:0]   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   // AXI4-Lite read
   input  wire logic [blit_pkg::AXI_AW-1:0]   s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [blit_pkg::AXI_DW-1:0]        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   // Geometry from the engine's other registers
   input  wire logic [blit_pkg::ADDR_W-1:0]   src_base,
   input  wire logic [blit_pkg::ADDR_W-1:0]   dst_base,
   input  wire logic [blit_pkg::ADDR_W-1:0]   row_offset,
   input  wire logic [blit_pkg::DIM_W-1:0]    blk_width,
   input  wire logic [blit_pkg::DIM_W-1:0]    blk_height,
   input  wire logic                          read_op,
   // FIFO drain by the host data port
   input  wire logic                          fifo_pop,
   // Engine address walk
   output logic [blit_pkg::ADDR_W-1:0]        src_addr,
   output logic [blit_pkg::ADDR_W-1:0]        dst_addr,
   output logic                               pixel_strobe,
   output logic                               fifo_stalled,
   // Interrupt
   output logic                               irq
);
   fifo_level_if lvl ();

   blit_fifo_level u_level (
      .clk    (clk),
      .arst_n (arst_n),
      .lvl    (lvl.tracker)
   );

   function automatic logic hits(input logic [blit_pkg::AXI_AW-1:0] addr,
                                 input logic [15:0] ofs);
      hits = (addr[15:2] == ofs[15:2]);
   endfunction : hits

   function automatic logic [blit_pkg::ADDR_W-1:0] row_step(
      input logic [blit_pkg::ADDR_W-1:0] ptr,
      input logic [blit_pkg::ADDR_W-1:0] row,
      input logic                        linear,
      input logic                        row_end,
      input logic [blit_pkg::ADDR_W-1:0] step,
      input logic [blit_pkg::ADDR_W-1:0] ofs);
      if (row_end && !linear) begin
         row_step = row + ofs;
      end else begin
         row_step = ptr + step;
      end
   endfunction : row_step

   // Control and interrupt state
   logic                       src_linear;
   logic                       dst_linear;
   logic                       color_16bpp;
   logic [blit_pkg::IRQ_W-1:0] irq_stat;
   logic [blit_pkg::IRQ_W-1:0] irq_mask;

   // Write channel holding
   logic                        aw_held;
   logic                        w_held;
   logic [blit_pkg::AXI_AW-1:0] wr_addr;
   logic [blit_pkg::AXI_DW-1:0] wr_data;
   logic [3:0]                  wr_strb;
   logic                        do_write;

   // Engine
   blit_pkg::engine_state_e     state;
   logic [blit_pkg::ADDR_W-1:0] src_ptr;
   logic [blit_pkg::ADDR_W-1:0] dst_ptr;
   logic [blit_pkg::ADDR_W-1:0] src_row;
   logic [blit_pkg::ADDR_W-1:0] dst_row;
   logic [blit_pkg::ADDR_W-1:0] step;
   logic [blit_pkg::DIM_W-1:0]  x_cnt;
   logic [blit_pkg::DIM_W-1:0]  y_cnt;
   logic                        paused;
   logic                        start;
   logic                        advance;
   logic                        row_end;
   logic                        last_pix;
   logic                        busy;
   logic [blit_pkg::ADDR_W-1:0] next_src;
   logic [blit_pkg::ADDR_W-1:0] next_dst;
   logic [blit_pkg::IRQ_W-1:0]  irq_set;
   logic [blit_pkg::IRQ_W-1:0]  irq_clr;
   logic [blit_pkg::AXI_DW-1:0] status_word;

   // AXI write: address and data taken in either order, one at a time
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held <= 1'b0;
         wr_addr <= 16'h0000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         wr_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         w_held  <= 1'b0;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held  <= 1'b1;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= blit_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if (hits(wr_addr, blit_pkg::CTRL_OFS) || hits(wr_addr, blit_pkg::IRQ_STAT_OFS)
             || hits(wr_addr, blit_pkg::IRQ_MASK_OFS)
             || hits(wr_addr, blit_pkg::STAT_OFS)) begin
            s_axi_bresp <= blit_pkg::RESP_OKAY;
         end else begin
            s_axi_bresp <= blit_pkg::RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control register; only bits 18:16 are stored
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         src_linear  <= blit_pkg::CTRL_RESET[blit_pkg::CTRL_SRC_LIN_BIT];
         dst_linear  <= blit_pkg::CTRL_RESET[blit_pkg::CTRL_DST_LIN_BIT];
         color_16bpp <= blit_pkg::CTRL_RESET[blit_pkg::CTRL_BPP_BIT];
      end else if (do_write && hits(wr_addr, blit_pkg::CTRL_OFS) && wr_strb[2]) begin
         src_linear  <= wr_data[blit_pkg::CTRL_SRC_LIN_BIT];
         dst_linear  <= wr_data[blit_pkg::CTRL_DST_LIN_BIT];
         color_16bpp <= wr_data[blit_pkg::CTRL_BPP_BIT];
      end
   end

   // Start is a pulse; a write while busy cannot restart or abort the walk
   assign start = do_write && hits(wr_addr, blit_pkg::CTRL_OFS) && wr_strb[0]
                  && wr_data[blit_pkg::CTRL_START_BIT] && (state == blit_pkg::st_idle);

   // Interrupt mask and sticky status, set wins over write-one-to-clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_mask <= blit_pkg::IRQ_RESET;
      end else if (do_write && hits(wr_addr, blit_pkg::IRQ_MASK_OFS) && wr_strb[0]) begin
         irq_mask <= wr_data[blit_pkg::IRQ_W-1:0];
      end
   end

   assign irq_clr = (do_write && hits(wr_addr, blit_pkg::IRQ_STAT_OFS) && wr_strb[0])
                    ? wr_data[blit_pkg::IRQ_W-1:0] : blit_pkg::IRQ_RESET;

   always_comb begin
      irq_set = blit_pkg::IRQ_RESET;
      irq_set[blit_pkg::IRQ_DONE_BIT] = advance && last_pix;
      irq_set[blit_pkg::IRQ_FULL_BIT] = lvl.push_ok && !lvl.pop_ok
                                        && (lvl.count == blit_pkg::FIFO_DEPTH - 5'h01);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat <= blit_pkg::IRQ_RESET;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // Engine walker
   assign busy     = (state == blit_pkg::st_run);
   assign step     = color_16bpp ? blit_pkg::STEP_16BPP : blit_pkg::STEP_8BPP;
   assign row_end  = (x_cnt + 10'h001 >= blk_width);
   assign last_pix = row_end && (y_cnt + 10'h001 >= blk_height);
   assign advance  = busy && !(read_op && (paused || lvl.count == blit_pkg::FIFO_DEPTH));
   assign next_src = row_step(src_ptr, src_row, src_linear, row_end, step, row_offset);
   assign next_dst = row_step(dst_ptr, dst_row, dst_linear, row_end, step, row_offset);

   // Hysteresis keeps the engine from thrashing at the full boundary
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         paused <= 1'b0;
      end else if (lvl.count == blit_pkg::FIFO_DEPTH) begin
         paused <= 1'b1;
      end else if (lvl.count < blit_pkg::RESUME_MARK) begin
         paused <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= blit_pkg::st_idle;
      end else begin
         case (state)
            blit_pkg::st_idle: begin
               if (start) begin
                  state <= blit_pkg::st_run;
               end
            end
            blit_pkg::st_run: begin
               if (advance && last_pix) begin
                  state <= blit_pkg::st_idle;
               end
            end
            default: begin
               state <= blit_pkg::st_idle;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         x_cnt <= blit_pkg::DIM_RESET;
         y_cnt <= blit_pkg::DIM_RESET;
      end else if (start) begin
         x_cnt <= blit_pkg::DIM_RESET;
         y_cnt <= blit_pkg::DIM_RESET;
      end else if (advance && row_end) begin
         x_cnt <= blit_pkg::DIM_RESET;
         y_cnt <= y_cnt + 10'h001;
      end else if (advance) begin
         x_cnt <= x_cnt + 10'h001;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         src_ptr <= blit_pkg::ADDR_RESET;
         dst_ptr <= blit_pkg::ADDR_RESET;
         src_row <= blit_pkg::ADDR_RESET;
         dst_row <= blit_pkg::ADDR_RESET;
      end else if (start) begin
         src_ptr <= src_base;
         dst_ptr <= dst_base;
         src_row <= src_base;
         dst_row <= dst_base;
      end else if (advance) begin
         src_ptr <= next_src;
         dst_ptr <= next_dst;
         if (row_end) begin
            src_row <= next_src;
            dst_row <= next_dst;
         end
      end
   end

   // Registered address outputs for the datapath
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         src_addr     <= blit_pkg::ADDR_RESET;
         dst_addr     <= blit_pkg::ADDR_RESET;
         pixel_strobe <= 1'b0;
      end else begin
         pixel_strobe <= advance;
         if (advance) begin
            src_addr <= src_ptr;
            dst_addr <= dst_ptr;
         end
      end
   end

   assign fifo_stalled = busy && !advance;

   // Read transfers fill the FIFO one entry per pixel
   assign lvl.push = advance && read_op;
   assign lvl.pop  = fifo_pop;

   // Status word; everything not listed reads zero
   always_comb begin
      status_word = blit_pkg::STAT_RESET;
      status_word[blit_pkg::STAT_BUSY_BIT] = busy;
      status_word[blit_pkg::STAT_FULL_BIT] = lvl.full;
      status_word[blit_pkg::STAT_HALF_BIT] = lvl.half_full;
      status_word[blit_pkg::STAT_NE_BIT]   = lvl.not_empty;
      status_word[blit_pkg::STAT_FREE_LSB +: blit_pkg::CNT_W] = lvl.free;
      status_word[blit_pkg::STAT_USED_LSB +: blit_pkg::CNT_W] = lvl.count;
   end

   // AXI read: one outstanding, answer registered one cycle after the take
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= blit_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= blit_pkg::RESP_OKAY;
         if (hits(s_axi_araddr, blit_pkg::CTRL_OFS)) begin
            s_axi_rdata <= {13'h0000, color_16bpp, dst_linear, src_linear,
                            16'h0000};
         end else if (hits(s_axi_araddr, blit_pkg::STAT_OFS)) begin
            s_axi_rdata <= status_word;
         end else if (hits(s_axi_araddr, blit_pkg::IRQ_STAT_OFS)) begin
            s_axi_rdata <= {30'h0000_0000, irq_stat};
         end else if (hits(s_axi_araddr, blit_pkg::IRQ_MASK_OFS)) begin
            s_axi_rdata <= {30'h0000_0000, irq_mask};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= blit_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : blit_regs

// ### verification/blit_regs_sva.sv
/*
 Concurrent checks on the read answers, status fields and FIFO pause of the bank.
 Assumes the single clk domain of blit_regs; attached by the bind at the foot.
*/
module blit_regs_sva (
   // Clock and reset
   input wire logic        clk,
   input wire logic        arst_n,
   // Read channel
   input wire logic [15:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   // Engine
   input wire logic        pixel_strobe,
   input wire logic        fifo_stalled,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   logic       take;
   logic       ctl;
   logic       sta;
   logic [4:0] used;
   assign take = s_axi_arvalid && s_axi_arready;
   assign ctl  = s_axi_araddr[15:2] == blit_pkg::CTRL_OFS[15:2];
   assign sta  = s_axi_araddr[15:2] == blit_pkg::STAT_OFS[15:2];
   assign used = s_axi_rdata[28:24];

   property p_rlat;
      take |=> s_axi_rvalid;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_rd_ok;
      take && (ctl || sta) |=> s_axi_rresp == blit_pkg::RESP_OKAY;
   endproperty
   a_rd_ok: assert property (p_rd_ok) else $error("mapped read refused");
   property p_rd_err;
      take && s_axi_araddr[15:8] != 8'h80 |=>
         s_axi_rresp == blit_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("unmapped read accepted");
   property p_ctl_rsv;
      take && ctl |=> (s_axi_rdata & 32'hfff8_ffff) == 32'h0;
   endproperty
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("control readback bits");
   property p_sta_rsv;
      take && sta |=> (s_axi_rdata & 32'he0e0_ff8e) == 32'h0;
   endproperty
   a_sta_rsv: assert property (p_sta_rsv) else $error("status spare bits set");
   property p_flags;
      take && sta |=> s_axi_rdata[6] == (used != 5'h0) && s_axi_rdata[5] == (used >= 5'h07)
         && s_axi_rdata[4] == (used >= 5'h0f);
   endproperty
   a_flags: assert property (p_flags) else $error("flags disagree with count");
   property p_free;
      take && sta |=> {1'b0, s_axi_rdata[20:16]} + {1'b0, used} == 6'h10;
   endproperty
   a_free: assert property (p_free) else $error("free plus used not 16");
   property p_stall;
      fifo_stalled ##1 fifo_stalled |-> !pixel_strobe;
   endproperty
   a_stall: assert property (p_stall) else $error("pixel issued while paused");

   c_stall: cover property (fifo_stalled);
   c_err: cover property (take && s_axi_araddr[15:8] != 8'h80);
   c_irq: cover property ($rose(irq));
endmodule : blit_regs_sva

bind blit_regs blit_regs_sva chk_i (.clk(clk), .arst_n(arst_n), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .pixel_strobe(pixel_strobe),
   .fifo_stalled(fifo_stalled), .irq(irq));

// ### verification/host_bus_model.sv
/*
 Host processor: AXI4-Lite master with blocking word tasks, plus the FIFO drain port.
 Assumes the same clock as the bank; raises hung when an answer never comes.
*/
module host_bus_model (
   // Clock
   input wire logic        clk,
   // Write
   output logic     [15:0] awaddr,
   output logic            awvalid,
   input wire logic        awready,
   output logic     [31:0] wdata,
   output logic     [3:0]  wstrb,
   output logic            wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   output logic            bready,
   // Read
   output logic     [15:0] araddr,
   output logic            arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   output logic            rready,
   // Drain and watchdog
   output logic            fifo_pop,
   output logic            hung
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      {awvalid, wvalid, bready, arvalid, rready, fifo_pop, hung} = '0;
   end

   task wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      resp = 2'h3;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 50 && !done; i++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) hung <= 1'b1;
   endtask : wr

   task rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] resp);
      logic done;
      done = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 50 && !done; i++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) hung <= 1'b1;
   endtask : rd

   // One entry drained per call
   task pop;
      @(posedge clk);
      fifo_pop <= 1'b1;
      @(posedge clk);
      fifo_pop <= 1'b0;
   endtask : pop
endmodule : host_bus_model

// ### verification/blit_regs_test.sv
/*
 Self-checking bench of the block-transfer register bank, host model on the bus.
 Assumes blit_regs with its checker bound; geometry inputs driven here.
*/
module blit_regs_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0, arst_n = 1'b0, read_op = 1'b0;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, fifo_pop, hung;
   logic        pixel_strobe, fifo_stalled, irq;
   logic [19:0] src_base = 20'h00100, dst_base = 20'h00200, row_offset = 20'h00040;
   logic [19:0] src_addr, dst_addr, sq[$], dq[$];
   logic [9:0]  blk_width = 10'h003, blk_height = 10'h003;
   logic [2:0]  modes[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
   int          miscompares, compares;

   always #12.5 clk = ~clk;

   blit_regs blit_regs_i (.clk(clk), .arst_n(arst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .src_base(src_base), .dst_base(dst_base), .row_offset(row_offset),
      .blk_width(blk_width), .blk_height(blk_height), .read_op(read_op), .fifo_pop(fifo_pop),
      .src_addr(src_addr), .dst_addr(dst_addr), .pixel_strobe(pixel_strobe),
      .fifo_stalled(fifo_stalled), .irq(irq));

   host_bus_model host_bus_model_i (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .fifo_pop(fifo_pop), .hung(hung));

   always @(posedge clk) if (pixel_strobe) begin
      sq.push_back(src_addr);
      dq.push_back(dst_addr);
   end

   task print_verdict;
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   always @(posedge hung) begin
      miscompares++;
      print_verdict();
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // Status word for n words held, from the flag table
   function automatic logic [31:0] st(input logic b, input int n);
      st = {3'h0, 5'(n), 3'h0, 5'(16 - n), 9'h0, n != 0, n >= 7, n >= 15, 3'h0, b};
   endfunction : st

   function automatic logic [19:0] ax(input logic [19:0] b, input logic lin, input int k,
                                      input int stp);
      ax = lin ? b + 20'(k * stp) : b + 20'(k / 3) * row_offset + 20'((k % 3) * stp);
   endfunction : ax

   task rd_stat;
      host_bus_model_i.rd(blit_pkg::STAT_OFS, d, r);
   endtask : rd_stat

   task wait_idle;
      int i;
      d = 32'h1;
      for (i = 0; i < 60 && d[0] !== 1'b0; i++) rd_stat();
      chk(d & 32'h1, 32'h0);
   endtask : wait_idle

   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      host_bus_model_i.rd(blit_pkg::CTRL_OFS, d, r);
      chk(d, 32'h0);
      rd_stat();
      chk(d, st(0, 0));
      host_bus_model_i.wr(blit_pkg::CTRL_OFS, 32'hfffe_fffe, r);
      host_bus_model_i.rd(blit_pkg::CTRL_OFS, d, r);
      chk(d, 32'h0006_0000);
      host_bus_model_i.wr(blit_pkg::STAT_OFS, 32'hffff_ffff, r);
      rd_stat();
      chk(d, st(0, 0));
      host_bus_model_i.wr(16'h9000, 32'h1, r);
      chk({30'h0, r}, {30'h0, blit_pkg::RESP_SLVERR});
      host_bus_model_i.rd(16'h9000, d, r);
      chk({30'h0, r}, {30'h0, blit_pkg::RESP_SLVERR});
      foreach (modes[m]) begin
         sq.delete();
         dq.delete();
         host_bus_model_i.wr(blit_pkg::CTRL_OFS, {13'h0, modes[m], 16'h0001}, r);
         rd_stat();
         chk(d, st(1, 0));
         wait_idle();
         for (int k = 0; k < 9; k++) begin
            chk(sq[k], ax(src_base, modes[m][0], k, modes[m][2] ? 2 : 1));
            chk(dq[k], ax(dst_base, modes[m][1], k, modes[m][2] ? 2 : 1));
         end
      end
      host_bus_model_i.rd(blit_pkg::IRQ_STAT_OFS, d, r);
      chk(d, 32'h1);
      chk({31'h0, irq}, 32'h0);
      host_bus_model_i.wr(blit_pkg::IRQ_MASK_OFS, 32'h1, r);
      chk({31'h0, irq}, 32'h1);
      host_bus_model_i.wr(blit_pkg::IRQ_STAT_OFS, 32'h1, r);
      chk({31'h0, irq}, 32'h0);
      // Read transfer of 17 words: one more than a 16-entry FIFO holds, so the engine stalls at 16
      @(posedge clk);
      read_op <= 1'b1;
      blk_width <= 10'h011;
      blk_height <= 10'h001;
      host_bus_model_i.wr(blit_pkg::CTRL_OFS, 32'h1, r);
      for (int i = 0; i < 100 && fifo_stalled !== 1'b1; i++) @(posedge clk);
      chk({31'h0, fifo_stalled}, 32'h1);
      rd_stat();
      chk(d, st(1, 16));
      repeat (2) begin
         host_bus_model_i.pop();
         repeat (3) @(posedge clk);
         chk({31'h0, fifo_stalled}, 32'h1);
      end
      host_bus_model_i.pop();
      wait_idle();
      for (int n = 14; n >= 0; n--) begin
         rd_stat();
         chk(d, st(0, n));
         host_bus_model_i.pop();
      end
      host_bus_model_i.rd(blit_pkg::IRQ_STAT_OFS, d, r);
      chk(d, 32'h3);
      chk({31'h0, irq}, 32'h1);
      print_verdict();
   end
endmodule : blit_regs_test
